// >>> logic/srfc_div.sv
// restoring divider, one quotient bit per clock
// assumes den_i is nonzero and stable only at start_i; start_i restarts a running division
`timescale 1ns/1ps
`default_nettype none
module srfc_div #(
  parameter int NW = 32,
  parameter int DW = 17
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic [NW-1:0] num_i,
  input wire logic [DW-1:0] den_i,
  output logic busy_o,
  output logic done_o,
  output logic [NW-1:0] quot_o
);
  logic [DW-1:0] den_r;
  logic [DW-1:0] rem_r;
  logic [NW-1:0] q_r;
  logic [5:0] cnt_r;
  logic [DW:0] shift_v;
  logic [DW:0] diff_v;
  logic [NW-1:0] q_nxt;
  logic [DW-1:0] rem_nxt;

  always_comb
  begin
    shift_v = {rem_r, q_r[NW-1]};
    diff_v = shift_v - {1'b0, den_r};
    if (shift_v >= {1'b0, den_r})
    begin
      rem_nxt = diff_v[DW-1:0];
      q_nxt = {q_r[NW-2:0], 1'b1};
    end
    else
    begin
      rem_nxt = shift_v[DW-1:0];
      q_nxt = {q_r[NW-2:0], 1'b0};
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      busy_o <= 1'b0;
      done_o <= 1'b0;
      cnt_r <= 6'h00;
      rem_r <= '0;
      q_r <= '0;
      den_r <= '0;
      quot_o <= '0;
    end
    else
    begin
      done_o <= 1'b0;
      if (start_i)
      begin
        busy_o <= 1'b1;
        cnt_r <= 6'h00;
        rem_r <= '0;
        q_r <= num_i;
        den_r <= den_i;
      end
      else if (busy_o)
      begin
        rem_r <= rem_nxt;
        q_r <= q_nxt;
        cnt_r <= cnt_r + 6'h01;
        if (cnt_r == 6'(NW - 1))
        begin
          busy_o <= 1'b0;
          done_o <= 1'b1;
          quot_o <= q_nxt;
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> logic/srfc_pkg.sv
// register map, field layout, reset values and lookup for the resonance filter config block
// assumes a 32-bit classic wishbone slave with byte addresses and one word per register
package srfc_pkg;
  localparam int ADR_W = 8;
  localparam int DAT_W = 32;
  localparam int REG_W = 16;

  localparam logic [7:0] A_VIB_MODE = 8'h00;
  localparam logic [7:0] A_SHAFT_CODE = 8'h04;
  localparam logic [7:0] A_FILT_SEL = 8'h08;
  localparam logic [7:0] A_LPF_MAN = 8'h0c;
  localparam logic [7:0] A_GAIN_MODE = 8'h10;
  localparam logic [7:0] A_VIB_OPT = 8'h14;
  localparam logic [7:0] A_SPD_GAIN = 8'h18;
  localparam logic [7:0] A_INERTIA = 8'h1c;
  localparam logic [7:0] A_MOTOR = 8'h20;
  localparam logic [7:0] A_STAGE_BASE = 8'h24;
  localparam logic [7:0] A_STAGE_LAST = 8'h40;
  localparam logic [7:0] A_STATUS = 8'h44;
  localparam logic [7:0] A_LPF_FREQ = 8'h48;

  // digit fields: vibration tuning mode holds stage s at s*DIG_W, filter selection likewise
  localparam int DIG_W = 4;
  localparam int SEL_SHAFT_LSB = 0;
  localparam int SEL_LPF_LSB = 4;
  localparam logic [3:0] DIG_OFF = 4'h0;
  localparam logic [3:0] DIG_AUTO = 4'h1;
  localparam logic [3:0] DIG_MAN = 4'h2;
  localparam logic [3:0] SH_AUTO = 4'h0;
  localparam logic [3:0] SH_MAN = 4'h1;
  localparam logic [3:0] SH_OFF = 4'h2;
  localparam logic [3:0] LP_AUTO = 4'h0;
  localparam logic [3:0] LP_MAN = 4'h1;
  localparam logic [3:0] LP_OFF = 4'h2;
  localparam logic [3:0] GM_AUTO2 = 4'h2;
  localparam logic [3:0] GM_MANUAL = 4'h3;
  localparam logic [3:0] GM_TWO_GAIN = 4'h4;
  localparam logic [15:0] VIB_OPT_ON = 16'h0001;

  // status bits
  localparam int ST_S1_AUTO = 0;
  localparam int ST_S2_AUTO = 1;
  localparam int ST_VIB_ON = 2;
  localparam int ST_RANGE_ERR = 3;
  localparam int ST_LPF_BUSY = 4;

  localparam logic [4:0] SH_CODE_FIRST = 5'h02;
  localparam logic [4:0] SH_AUTO_BASE = 5'h0a;
  localparam logic [4:0] SH_CODE_MAX = 5'h1f;
  localparam int SH_RATIO_SHIFT = 5;
  localparam int SH_MOTOR_SHIFT = 2;

  // estimated frequencies in 0.1 Hz
  localparam logic [15:0] EST_MIN = 16'h000a;
  localparam logic [15:0] EST_MAX = 16'h03e8;

  // corner = gain*10 / (1 + ratio), ratio in 0.1 units: gain*100 / (10 + ratio)
  localparam int DIV_NW = 32;
  localparam int DIV_DW = 17;
  localparam logic [31:0] LPF_MULT = 32'h0000_0064;
  localparam logic [16:0] RATIO_ONE = 17'h0000a;

  localparam logic [7:0] POS_TUNE_COUNT = 8'h0a;
  localparam logic [7:0] POS_LAST = POS_TUNE_COUNT - 8'h01;

  localparam logic [15:0] RST_LPF_MAN = 16'h0bb8;
  localparam logic [15:0] RST_GAIN_MODE = 16'h0001;
  localparam logic [15:0] RST_SPD_GAIN = 16'h0320;
  localparam logic [15:0] RST_INERTIA = 16'h0046;
  localparam logic [15:0] RST_ZERO = 16'h0000;

  function automatic logic [15:0] wr16(input logic [15:0] old, input logic [15:0] nw,
                                       input logic [1:0] sel);
    logic [15:0] r;
    r = old;
    if (sel[0])
    begin
      r[7:0] = nw[7:0];
    end
    if (sel[1])
    begin
      r[15:8] = nw[15:8];
    end
    return r;
  endfunction

  // shaft filter code to frequency in hz, 0 means disabled
  function automatic logic [12:0] shaft_hz(input logic [4:0] c);
    logic [12:0] f;
    case (c)
      5'h02: f = 13'h1194;
      5'h03: f = 13'h0bb8;
      5'h04: f = 13'h08ca;
      5'h05: f = 13'h0708;
      5'h06: f = 13'h05dc;
      5'h07: f = 13'h0505;
      5'h08: f = 13'h0465;
      5'h09: f = 13'h03e8;
      5'h0a: f = 13'h0384;
      5'h0b: f = 13'h0332;
      5'h0c: f = 13'h02ee;
      5'h0d: f = 13'h02b4;
      5'h0e: f = 13'h0282;
      5'h0f: f = 13'h0258;
      5'h10: f = 13'h0232;
      5'h11: f = 13'h0211;
      5'h12: f = 13'h01f4;
      5'h13: f = 13'h01d9;
      5'h14: f = 13'h01c2;
      5'h15: f = 13'h01ac;
      5'h16: f = 13'h0199;
      5'h17: f = 13'h0187;
      5'h18: f = 13'h0177;
      5'h19: f = 13'h0168;
      5'h1a: f = 13'h015a;
      5'h1b: f = 13'h014d;
      5'h1c: f = 13'h0141;
      5'h1d: f = 13'h0136;
      5'h1e: f = 13'h012c;
      5'h1f: f = 13'h0122;
      default: f = 13'h0000;
    endcase
    return f;
  endfunction
endpackage

// >>> logic/srfc_top.sv
// resonance filter configuration: shaft filter, torque low-pass, two vibration stages
// assumes a classic wishbone master on clk_i and a motor loop on the same clock
//
// Decided for this implementation: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - shaft selection digit chooses derived code or software-written code.
// - codes 00 and 01 disable shaft filter; 02..1F map 4500 Hz down to 290 Hz.
// - torque low-pass filter is on after reset with no setup.
// - automatic corner in rad/s is speed gain over one plus inertia ratio, times ten.
// - low-pass digit 1 selects the manual low-pass frequency register.
// - vibration stages work only in gain adjust modes 2, 3 and 4.
// - estimates outside 1.0 to 100.0 Hz are rejected; set those manually.
// - tuning estimates load vibration, at most two, one per stage.
// - after set number of positionings an automatic stage turns itself manual.
// - manual stage 1 uses its four parameters, stage 2 its own four.
// - low tuning digit: 0 off, 1 automatic writes stage 1 set, 2 manual.
// - second tuning digit: 0 off, 1 automatic writes stage 2 set, 2 manual.
// - automatic shaft code follows motor type and inertia ratio.
module srfc_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [srfc_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [srfc_pkg::DAT_W-1:0] wb_dat_i,
  output logic [srfc_pkg::DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic pos_done_i,
  input wire logic est_valid_i,
  input wire logic est_stage_i,
  input wire logic [15:0] est_vib_freq_i,
  input wire logic [15:0] est_res_freq_i,
  input wire logic [15:0] est_vib_damp_i,
  input wire logic [15:0] est_res_damp_i,
  output logic shaft_en_o,
  output logic [12:0] shaft_freq_hz_o,
  output logic lpf_en_o,
  output logic [15:0] lpf_freq_o,
  output logic stage1_en_o,
  output logic stage2_en_o,
  output logic stage1_tune_o,
  output logic stage2_tune_o,
  output logic [15:0] s1_vib_freq_o,
  output logic [15:0] s1_res_freq_o,
  output logic [15:0] s1_vib_damp_o,
  output logic [15:0] s1_res_damp_o,
  output logic [15:0] s2_vib_freq_o,
  output logic [15:0] s2_res_freq_o,
  output logic [15:0] s2_vib_damp_o,
  output logic [15:0] s2_res_damp_o
);
  import srfc_pkg::*;

  logic [15:0] vib_mode_r;
  logic [15:0] vib_mode_nxt;
  logic [15:0] shaft_code_r;
  logic [15:0] filt_sel_r;
  logic [15:0] lpf_man_r;
  logic [15:0] gain_mode_r;
  logic [15:0] vib_opt_r;
  logic [15:0] spd_gain_r;
  logic [15:0] inertia_r;
  logic [15:0] motor_r;
  logic [15:0] stage_r [0:7];
  logic [7:0] pos_cnt_r [0:1];
  logic range_err_r;
  logic lpf_req_r;
  logic [15:0] lpf_calc_r;
  logic ack_r;

  logic bus_req;
  logic bus_wr;
  logic [7:0] stage_off;
  logic stage_hit;
  logic [2:0] stage_idx;
  logic [15:0] wr_val;
  logic [3:0] shaft_dig;
  logic [3:0] lpf_dig;
  logic [3:0] vib_dig [0:1];
  logic vib_on;
  logic stage_on [0:1];
  logic stage_auto [0:1];
  logic pos_hit [0:1];
  logic est_in_range;
  logic est_take;
  logic [4:0] shaft_auto;
  logic [4:0] shaft_sum;
  logic div_busy;
  logic div_done;
  logic [DIV_NW-1:0] div_quot;
  logic [DIV_NW-1:0] div_num;
  logic [DIV_DW-1:0] div_den;
  logic [15:0] status_v;
  logic [15:0] rd_val;

  assign bus_req = wb_cyc_i & wb_stb_i & ~ack_r;
  // writes land at the edge where the master samples ack high
  assign bus_wr = wb_cyc_i & wb_stb_i & wb_we_i & ack_r;
  assign stage_off = wb_adr_i - A_STAGE_BASE;
  assign stage_hit = (wb_adr_i >= A_STAGE_BASE) && (wb_adr_i <= A_STAGE_LAST)
                     && (wb_adr_i[1:0] == 2'b00);
  assign stage_idx = stage_off[4:2];

  always_comb
  begin
    wr_val = wr16(rd_val, wb_dat_i[15:0], wb_sel_i[1:0]);
  end

  assign shaft_dig = filt_sel_r[SEL_SHAFT_LSB +: DIG_W];
  assign lpf_dig = filt_sel_r[SEL_LPF_LSB +: DIG_W];

  // vibration control is only alive in the three gain modes that support it
  assign vib_on = (gain_mode_r[3:0] == GM_AUTO2) || (gain_mode_r[3:0] == GM_MANUAL)
                  || (gain_mode_r[3:0] == GM_TWO_GAIN);

  always_comb
  begin
    for (int s = 0; s < 2; s++)
    begin
      vib_dig[s] = vib_mode_r[s*DIG_W +: DIG_W];
      stage_on[s] = vib_on && ((vib_dig[s] == DIG_AUTO) || (vib_dig[s] == DIG_MAN));
      if (s == 1)
      begin
        stage_on[s] = stage_on[s] && (vib_opt_r == VIB_OPT_ON);
      end
      stage_auto[s] = stage_on[s] && (vib_dig[s] == DIG_AUTO);
      pos_hit[s] = stage_auto[s] && pos_done_i && (pos_cnt_r[s] == POS_LAST);
    end
  end

  // estimates outside the tunable band are dropped and flagged
  assign est_in_range = (est_vib_freq_i >= EST_MIN) && (est_vib_freq_i <= EST_MAX)
                        && (est_res_freq_i >= EST_MIN) && (est_res_freq_i <= EST_MAX);
  assign est_take = est_valid_i && est_in_range && stage_auto[est_stage_i];

  // derived shaft code: heavier load and larger motor class push toward lower frequency
  assign shaft_sum = SH_AUTO_BASE + 5'(motor_r[1:0] << SH_MOTOR_SHIFT);
  always_comb
  begin
    if ((inertia_r >> SH_RATIO_SHIFT) >= 16'(SH_CODE_MAX - shaft_sum))
    begin
      shaft_auto = SH_CODE_MAX;
    end
    else
    begin
      shaft_auto = shaft_sum + 5'(inertia_r >> SH_RATIO_SHIFT);
    end
  end

  always_comb
  begin
    status_v = '0;
    status_v[ST_S1_AUTO] = stage_auto[0];
    status_v[ST_S2_AUTO] = stage_auto[1];
    status_v[ST_VIB_ON] = vib_on;
    status_v[ST_RANGE_ERR] = range_err_r;
    status_v[ST_LPF_BUSY] = div_busy | lpf_req_r;
  end

  always_comb
  begin
    rd_val = '0;
    if (stage_hit)
    begin
      rd_val = stage_r[stage_idx];
    end
    else
    begin
      case (wb_adr_i)
        A_VIB_MODE: rd_val = vib_mode_r;
        A_SHAFT_CODE: rd_val = shaft_code_r;
        A_FILT_SEL: rd_val = filt_sel_r;
        A_LPF_MAN: rd_val = lpf_man_r;
        A_GAIN_MODE: rd_val = gain_mode_r;
        A_VIB_OPT: rd_val = vib_opt_r;
        A_SPD_GAIN: rd_val = spd_gain_r;
        A_INERTIA: rd_val = inertia_r;
        A_MOTOR: rd_val = motor_r;
        A_STATUS: rd_val = status_v;
        A_LPF_FREQ: rd_val = lpf_calc_r;
        default: rd_val = '0;
      endcase
    end
  end

  // bus answer: ack one cycle after the request, low again the next cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_r <= 1'b0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end
    else
    begin
      ack_r <= bus_req;
      wb_ack_o <= bus_req;
      if (bus_req && !wb_we_i)
      begin
        wb_dat_o <= {16'h0000, rd_val};
      end
    end
  end

  // tuning mode: software write first, then the automatic hand-over to manual
  always_comb
  begin
    vib_mode_nxt = vib_mode_r;
    if (bus_wr && wb_adr_i == A_VIB_MODE)
    begin
      vib_mode_nxt = wr_val;
    end
    for (int s = 0; s < 2; s++)
    begin
      if (pos_hit[s])
      begin
        vib_mode_nxt[s*DIG_W +: DIG_W] = DIG_MAN;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      vib_mode_r <= RST_ZERO;
    end
    else
    begin
      vib_mode_r <= vib_mode_nxt;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pos_cnt_r[0] <= 8'h00;
      pos_cnt_r[1] <= 8'h00;
    end
    else
    begin
      for (int s = 0; s < 2; s++)
      begin
        if (!stage_auto[s] || pos_hit[s])
        begin
          pos_cnt_r[s] <= 8'h00;
        end
        else if (pos_done_i)
        begin
          pos_cnt_r[s] <= pos_cnt_r[s] + 8'h01;
        end
      end
    end
  end

  // plain configuration registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      filt_sel_r <= RST_ZERO;
      lpf_man_r <= RST_LPF_MAN;
      gain_mode_r <= RST_GAIN_MODE;
      vib_opt_r <= RST_ZERO;
      spd_gain_r <= RST_SPD_GAIN;
      inertia_r <= RST_INERTIA;
      motor_r <= RST_ZERO;
    end
    else if (bus_wr)
    begin
      case (wb_adr_i)
        A_FILT_SEL: filt_sel_r <= wr_val;
        A_LPF_MAN: lpf_man_r <= wr_val;
        A_GAIN_MODE: gain_mode_r <= wr_val;
        A_VIB_OPT: vib_opt_r <= wr_val;
        A_SPD_GAIN: spd_gain_r <= wr_val;
        A_INERTIA: inertia_r <= wr_val;
        A_MOTOR: motor_r <= wr_val;
        default: ;
      endcase
    end
  end

  // shaft code follows the derivation in automatic mode, software otherwise
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      shaft_code_r <= RST_ZERO;
    end
    else if (shaft_dig == SH_AUTO)
    begin
      shaft_code_r <= 16'(shaft_auto);
    end
    else if (bus_wr && wb_adr_i == A_SHAFT_CODE)
    begin
      shaft_code_r <= wr_val;
    end
  end

  // stage parameter sets: estimator writes win over a software write in the same cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i < 8; i++)
      begin
        stage_r[i] <= RST_ZERO;
      end
    end
    else
    begin
      if (bus_wr && stage_hit)
      begin
        stage_r[stage_idx] <= wr_val;
      end
      if (est_take)
      begin
        stage_r[{est_stage_i, 2'd0}] <= est_vib_freq_i;
        stage_r[{est_stage_i, 2'd1}] <= est_res_freq_i;
        stage_r[{est_stage_i, 2'd2}] <= est_vib_damp_i;
        stage_r[{est_stage_i, 2'd3}] <= est_res_damp_i;
      end
    end
  end

  // sticky out-of-band flag, write one to clear, a new event wins
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      range_err_r <= 1'b0;
    end
    else if (est_valid_i && !est_in_range)
    begin
      range_err_r <= 1'b1;
    end
    else if (bus_wr && wb_adr_i == A_STATUS && wb_sel_i[0] && wb_dat_i[ST_RANGE_ERR])
    begin
      range_err_r <= 1'b0;
    end
  end

  // corner recompute request: pending after reset and after each gain or ratio write
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      lpf_req_r <= 1'b1;
    end
    else if (bus_wr && (wb_adr_i == A_SPD_GAIN || wb_adr_i == A_INERTIA))
    begin
      lpf_req_r <= 1'b1;
    end
    else
    begin
      lpf_req_r <= 1'b0;
    end
  end

  assign div_num = 32'(spd_gain_r) * LPF_MULT;
  assign div_den = 17'(inertia_r) + RATIO_ONE;

  srfc_div #(
    .NW(DIV_NW),
    .DW(DIV_DW)
  ) u_div (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(lpf_req_r),
    .num_i(div_num),
    .den_i(div_den),
    .busy_o(div_busy),
    .done_o(div_done),
    .quot_o(div_quot)
  );

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      lpf_calc_r <= RST_ZERO;
    end
    else if (div_done)
    begin
      lpf_calc_r <= (div_quot[31:16] != 16'h0000) ? 16'hffff : div_quot[15:0];
    end
  end

  // filter outputs toward the control loop
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      shaft_en_o <= 1'b0;
      shaft_freq_hz_o <= '0;
      lpf_en_o <= 1'b0;
      lpf_freq_o <= RST_ZERO;
    end
    else
    begin
      shaft_en_o <= (shaft_dig != SH_OFF) && (shaft_code_r[15:5] == 11'h000)
                    && (shaft_code_r[4:0] >= SH_CODE_FIRST);
      shaft_freq_hz_o <= shaft_hz(shaft_code_r[4:0]);
      lpf_en_o <= (lpf_dig != LP_OFF);
      lpf_freq_o <= (lpf_dig == LP_MAN) ? lpf_man_r : lpf_calc_r;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      stage1_en_o <= 1'b0;
      stage2_en_o <= 1'b0;
      stage1_tune_o <= 1'b0;
      stage2_tune_o <= 1'b0;
    end
    else
    begin
      stage1_en_o <= stage_on[0];
      stage2_en_o <= stage_on[1];
      stage1_tune_o <= stage_auto[0];
      stage2_tune_o <= stage_auto[1];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s1_vib_freq_o <= RST_ZERO;
      s1_res_freq_o <= RST_ZERO;
      s1_vib_damp_o <= RST_ZERO;
      s1_res_damp_o <= RST_ZERO;
      s2_vib_freq_o <= RST_ZERO;
      s2_res_freq_o <= RST_ZERO;
      s2_vib_damp_o <= RST_ZERO;
      s2_res_damp_o <= RST_ZERO;
    end
    else
    begin
      s1_vib_freq_o <= stage_r[0];
      s1_res_freq_o <= stage_r[1];
      s1_vib_damp_o <= stage_r[2];
      s1_res_damp_o <= stage_r[3];
      s2_vib_freq_o <= stage_r[4];
      s2_res_freq_o <= stage_r[5];
      s2_vib_damp_o <= stage_r[6];
      s2_res_damp_o <= stage_r[7];
    end
  end
endmodule
`default_nettype wire

// >>> verification/servo_resonance_filter_config_test.sv
// self-checking bench for srfc_top with the loop-side model
// assumes 125 MHz clock and reset held 12 cycles
`timescale 1ns/1ps
`default_nettype none
module servo_resonance_filter_config_test;
  import srfc_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat;
  logic ack, pos, ev, es, sh_en, lp_en, s1en, s2en, s1t, s2t;
  logic [15:0] ef, lpf, s1f, s2f, s1r, s1vd, s1rd, s2r, s2vd, s2rd;
  logic [12:0] sh_hz;
  int fails = 0;
  int samples_checked = 0;
  srfc_loop_model i_srfc_loop_model (.clk_i(clk_i), .pos_done_o(pos), .est_valid_o(ev),
    .est_stage_o(es), .est_freq_o(ef));
  srfc_top i_srfc_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .pos_done_i(pos), .est_valid_i(ev), .est_stage_i(es),
    .est_vib_freq_i(ef), .est_res_freq_i(ef), .est_vib_damp_i(ef), .est_res_damp_i(ef),
    .shaft_en_o(sh_en), .shaft_freq_hz_o(sh_hz), .lpf_en_o(lp_en), .lpf_freq_o(lpf),
    .stage1_en_o(s1en), .stage2_en_o(s2en), .stage1_tune_o(s1t), .stage2_tune_o(s2t),
    .s1_vib_freq_o(s1f), .s1_res_freq_o(s1r), .s1_vib_damp_o(s1vd), .s1_res_damp_o(s1rd),
    .s2_vib_freq_o(s2f), .s2_res_freq_o(s2r), .s2_vib_damp_o(s2vd), .s2_res_damp_o(s2rd));
  initial
  begin
    forever #4 clk_i = ~clk_i;
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d,
                     output logic [31:0] q);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'h3;
    wdat <= {16'h0000, d};
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1)
    begin
      fails++;
      print_verdict();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
    repeat (3) @(posedge clk_i);
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 16'h0000, q);
    chk(nm, q, e);
  endtask
  task automatic wait_lpf(input logic [15:0] e);
    for (int n = 0; n < 100 && lpf !== e; n++)
      @(posedge clk_i);
    chk("lpf_freq", {16'h0000, lpf}, {16'h0000, e});
  endtask
  task automatic t_lowpass();
    chk("lpf_en", {31'h0, lp_en}, 32'h1);
    rd("filter_selection", A_FILT_SEL, 32'h0);
    rd("unmapped", 8'hf0, 32'h0);
    wait_lpf(16'h03e8);
    wr(A_SPD_GAIN, 16'h0190);
    wr(A_INERTIA, 16'h000a);
    wait_lpf(16'h07d0);
    wr(A_FILT_SEL, 16'h0010);
    wait_lpf(16'h0bb8);
    wr(A_FILT_SEL, 16'h0020);
    chk("lpf_off", {31'h0, lp_en}, 32'h0);
    wr(A_FILT_SEL, 16'h0000);
    wr(A_INERTIA, 16'h0046);
    wait_lpf(16'h01f4);
  endtask
  task automatic t_shaft();
    logic [4:0] code[5] = '{5'h00, 5'h01, 5'h02, 5'h0a, 5'h1f};
    logic [12:0] hz[5] = '{13'h0000, 13'h0000, 13'h1194, 13'h0384, 13'h0122};
    chk("shaft_auto_hz", {19'h0, sh_hz}, 32'h2ee);
    rd("shaft_code", A_SHAFT_CODE, 32'h000c);
    wr(A_FILT_SEL, 16'h0001);
    for (int i = 0; i < 5; i++)
    begin
      wr(A_SHAFT_CODE, {11'h0, code[i]});
      chk("shaft_hz", {19'h0, sh_hz}, {19'h0, hz[i]});
      chk("shaft_en", {31'h0, sh_en}, {31'h0, hz[i] != 13'h0});
    end
    wr(A_FILT_SEL, 16'h0002);
    chk("shaft_off", {31'h0, sh_en}, 32'h0);
  endtask
  task automatic t_stages();
    wr(A_VIB_MODE, 16'h0022);
    wr(A_VIB_OPT, 16'h0001);
    for (int m = 1; m < 6; m++)
    begin
      wr(A_GAIN_MODE, 16'(m));
      chk("stage1_en", {31'h0, s1en}, {31'h0, m >= 2 && m <= 4});
      chk("stage2_en", {31'h0, s2en}, {31'h0, m >= 2 && m <= 4});
    end
    wr(A_GAIN_MODE, 16'h0003);
    wr(8'h24, 16'h1234);
    wr(8'h34, 16'h0abc);
    chk("s1_freq", {16'h0, s1f}, 32'h1234);
    chk("s2_freq", {16'h0, s2f}, 32'h0abc);
    wr(A_VIB_MODE, 16'h0021);
    chk("tune", {30'h0, s2t, s1t}, 32'h1);
    wr(A_VIB_MODE, 16'h0012);
    chk("tune", {30'h0, s2t, s1t}, 32'h2);
  endtask
  task automatic t_auto();
    logic [31:0] q;
    wr(A_VIB_MODE, 16'h0011);
    i_srfc_loop_model.est(1'b0, 16'h01f4);
    i_srfc_loop_model.est(1'b1, 16'h0064);
    i_srfc_loop_model.est(1'b0, 16'h0400);
    repeat (3) @(posedge clk_i);
    chk("s1_est", {16'h0, s1f}, 32'h01f4);
    chk("s2_est", {16'h0, s2f}, 32'h0064);
    chk("s1_set", {s1r, s1rd}, 32'h01f4_01f4);
    chk("s1_vdamp", {16'h0, s1vd}, 32'h01f4);
    chk("s2_set", {s2r, s2rd}, 32'h0064_0064);
    chk("s2_vdamp", {16'h0, s2vd}, 32'h0064);
    bus(1'b0, A_STATUS, 16'h0000, q);
    chk("range_err", {31'h0, q[ST_RANGE_ERR]}, 32'h1);
    wr(A_STATUS, 16'h0008);
    bus(1'b0, A_STATUS, 16'h0000, q);
    chk("range_clr", {31'h0, q[ST_RANGE_ERR]}, 32'h0);
    i_srfc_loop_model.positions(9);
    chk("tune_held", {30'h0, s2t, s1t}, 32'h3);
    i_srfc_loop_model.positions(1);
    chk("tune_done", {30'h0, s2t, s1t}, 32'h0);
    rd("vib_mode", A_VIB_MODE, 32'h0022);
  endtask
  initial
  begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    t_lowpass();
    t_shaft();
    t_stages();
    t_auto();
    print_verdict();
  end
  initial
  begin
    repeat (20000) @(posedge clk_i);
    fails++;
    print_verdict();
  end
endmodule
`default_nettype wire

// >>> verification/srfc_loop_model.sv
// loop-side model: positioning pulses and estimator results
// assumes the bench calls its tasks; drives after rising edges
`timescale 1ns/1ps
`default_nettype none
module srfc_loop_model (
  input wire logic clk_i,
  output logic pos_done_o = 1'b0,
  output logic est_valid_o = 1'b0,
  output logic est_stage_o = 1'b0,
  output logic [15:0] est_freq_o = 16'h0000
);
  task automatic est(input logic stage, input logic [15:0] f);
    @(posedge clk_i);
    est_valid_o <= 1'b1;
    est_stage_o <= stage;
    est_freq_o <= f;
    @(posedge clk_i);
    est_valid_o <= 1'b0;
    // released fields show garbage, not the last value
    est_stage_o <= ~stage;
    est_freq_o <= ~f;
  endtask
  task automatic positions(input int n);
    repeat (n)
    begin
      @(posedge clk_i);
      pos_done_o <= 1'b1;
      @(posedge clk_i);
      pos_done_o <= 1'b0;
      repeat (6) @(posedge clk_i);
    end
  endtask
endmodule
`default_nettype wire

// >>> verification/srfc_top_assertions.sv
// port checker for srfc_top
// assumes one clock clk_i and reset rst_i
`timescale 1ns/1ps
`default_nettype none
module srfc_top_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [srfc_pkg::DAT_W-1:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic est_valid_i,
  input wire logic est_stage_i,
  input wire logic [15:0] est_vib_freq_i,
  input wire logic [15:0] est_res_freq_i,
  input wire logic shaft_en_o,
  input wire logic [12:0] shaft_freq_hz_o,
  input wire logic lpf_en_o,
  input wire logic stage1_tune_o,
  input wire logic [15:0] s1_vib_freq_o
);
  import srfc_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_est1;
    est_valid_i && !est_stage_i && stage1_tune_o;
  endsequence
  AST_ACK_NEXT: assert property (s_req |=> wb_ack_o) else $error("ack late");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  AST_ACK_CAUSE: assert property ($rose(wb_ack_o) |-> $past(wb_stb_i) && $past(wb_cyc_i))
    else $error("ack without request");
  AST_DAT_HIGH: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
    else $error("upper read half set");
  AST_SHAFT_ZERO: assert property (shaft_freq_hz_o == 13'h0000 |-> !shaft_en_o)
    else $error("shaft on at zero");
  AST_SHAFT_BAND: assert property (shaft_en_o |-> shaft_freq_hz_o >= 13'h0122
    && shaft_freq_hz_o <= 13'h1194) else $error("shaft freq out of table");
  AST_LPF_DEFAULT: assert property ($fell(rst_i) |-> ##[0:2] lpf_en_o)
    else $error("lowpass off after reset");
  AST_EST_TAKE: assert property (s_est1 ##0 (est_vib_freq_i >= EST_MIN)
    ##0 (est_vib_freq_i <= EST_MAX && est_res_freq_i >= EST_MIN && est_res_freq_i <= EST_MAX)
    |=> (stage1_tune_o |-> ##1 s1_vib_freq_o == $past(est_vib_freq_i, 2)))
    else $error("estimate not taken");
  AST_EST_REJECT: assert property (s_est1 ##0 (est_vib_freq_i > EST_MAX)
    |-> ##2 $stable(s1_vib_freq_o)) else $error("estimate out of band taken");
endmodule
bind srfc_top srfc_top_chk i_srfc_top_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o,
  .wb_ack_o, .est_valid_i, .est_stage_i, .est_vib_freq_i, .est_res_freq_i, .shaft_en_o,
  .shaft_freq_hz_o, .lpf_en_o, .stage1_tune_o, .s1_vib_freq_o);
`default_nettype wire
